/* File: stepper_timing_ctrl.sv */
// Top of the stepper timing control: serial port, clock source, supervision, two choppers.
module stepper_timing_ctrl
(
    input  wire logic         clock_i,            // System clock, 250 MHz.
    input  wire logic         sys_rst_i,          // Synchronous reset, high.
    input  wire logic         ser_clk_i,          // Serial port clock.
    input  wire logic         ser_data_i,         // Serial port data.
    input  wire logic         ser_strobe_i,       // Serial strobe, idles high.
    input  wire logic         sleep_n_i,          // Sleep input, low sleeps.
    input  wire logic         timing_source_pin_i,// External timing clock.
    input  wire logic         int_osc_i,          // Internal oscillator level.
    input  wire logic         over_temp_i,        // Junction too hot.
    input  wire logic         pump_supply_low_i,  // Pump supply low.
    input  wire logic         sink_gate_supply_low_i, // Sink-gate supply low.
    input  wire logic         undervoltage_lockout_i, // Logic supply low.
    input  wire logic [1:0]   trip_i,             // Sense comparators, per bridge.
    input  wire logic [1:0]   zero_i,             // Zero current detect, per bridge.
    input  wire logic [1:0]   rev_lim_i,          // Reverse current limit, per bridge.
    output logic              pump_en_o,          // Charge pump enable.
    output logic              master_timebase_o,  // Selected timebase pulse.
    output logic [17:0]       bridge_word_o,      // Bridge word contents.
    output logic [17:0]       timing_config_word_o, // Timing word contents.
    output logic [3:0]        gate_hi_o,          // High sides: 1A,1B,2A,2B.
    output logic [3:0]        gate_lo_o           // Low sides: 1A,1B,2A,2B.
);
    import stepper_pkg::*;

    logic [WORD_BITS-1:0] shift_q;
    logic [4:0]           nbits_q;
    logic                 sclk_q;
    logic                 strobe_q;
    logic [17:0]          word0_q;
    logic [17:0]          word1_q;

    // Port clear from sleep or undervoltage.
    wire clear_port = !sleep_n_i || undervoltage_lockout_i;
    wire sclk_rise  = ser_clk_i && !sclk_q;
    // Word latches when strobe returns high after a write cycle.
    wire strobe_end = ser_strobe_i && !strobe_q;
    wire full_word  = nbits_q == 5'(WORD_BITS);

    // Serial shift: first bit lands at the top, select ends at bit 0.
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || clear_port)
        begin
            shift_q  <= 19'h0_0000;
            nbits_q  <= 5'h00;
            sclk_q   <= 1'b0;
            strobe_q <= 1'b1;
        end
        else
        begin
            sclk_q   <= ser_clk_i;
            strobe_q <= ser_strobe_i;
            if (ser_strobe_i)
                nbits_q <= 5'h00;
            else if (sclk_rise)
            begin
                shift_q <= {shift_q[WORD_BITS-2:0], ser_data_i};
                if (!full_word)
                    nbits_q <= nbits_q + 5'h01;
            end
        end
    end

    // Word store; the select bit picks the destination.
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || clear_port)
        begin
            word0_q <= WORD_RESET;
            word1_q <= WORD_RESET;
        end
        else if (strobe_end && nbits_q == 5'(WORD_BITS))
        begin
            if (shift_q[SEL_POS])
                word1_q <= shift_q[WORD_BITS-1:1];
            else
                word0_q <= shift_q[WORD_BITS-1:1];
        end
    end

    // Field access: word bit Dn is stored at index n-1.
    wire [1:0] clk_sel  = word1_q[CLKSEL_LSB-1 +: 2];
    wire       idle_rel = word1_q[IDLE_RELEASE_POS-1];

    // Timebase selection: internal and external levels edge-detected.
    logic int_q;
    logic ext_q;
    logic [1:0] div_q;
    wire  int_rise = int_osc_i && !int_q;
    wire  ext_rise = timing_source_pin_i && !ext_q;
    // Dividing the external clock counts its rising edges.
    wire  div_hit  = (clk_sel == CLK_EXT_DIV1)
                  || (clk_sel == CLK_EXT_DIV2 && div_q[0])
                  || (clk_sel == CLK_EXT_DIV4 && div_q == 2'b11);
    wire  tick     = (clk_sel == CLK_INTERNAL) ? int_rise : (ext_rise && div_hit);

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            int_q <= 1'b0;
            ext_q <= 1'b0;
            div_q <= 2'b00;
            master_timebase_o <= 1'b0;
        end
        else
        begin
            int_q <= int_osc_i;
            ext_q <= timing_source_pin_i;
            master_timebase_o <= tick;
            if (ext_rise)
                div_q <= div_q + 2'b01;
        end
    end

    // Bridge gates run only when awake, released from idle and fault free.
    wire fault = over_temp_i || pump_supply_low_i || sink_gate_supply_low_i;
    wire run   = idle_rel && !fault && !clear_port;

    timing_cfg_if cfg_bus ();
    assign cfg_bus.blank_code = word1_q[BLANK_LSB-1 +: 2];
    assign cfg_bus.off_code   = word1_q[OFF_LSB-1 +: 5];
    assign cfg_bus.fast_code  = word1_q[FAST_LSB-1 +: 4];
    assign cfg_bus.rect_mode  = word1_q[RECT_LSB-1 +: 2];
    assign cfg_bus.tick       = tick;
    assign cfg_bus.run        = run;

    // One chopper per bridge.
    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_bridge
            localparam int DLSB = (b == 0) ? DAC1_LSB : DAC2_LSB;
            localparam int PPOS = (b == 0) ? PHASE1_POS : PHASE2_POS;
            localparam int MPOS = (b == 0) ? MODE1_POS : MODE2_POS;
            bridge_chopper u_chop (
                .clock_i     (clock_i),
                .sys_rst_i   (sys_rst_i),
                .cfg         (cfg_bus),
                .dac_i       (word0_q[DLSB-1 +: 6]),
                .phase_i     (word0_q[PPOS-1]),
                .slow_only_i (word0_q[MPOS-1]),
                .trip_i      (trip_i[b]),
                .zero_i      (zero_i[b]),
                .rev_lim_i   (rev_lim_i[b]),
                .a_hi_o      (gate_hi_o[2*b]),
                .a_lo_o      (gate_lo_o[2*b]),
                .b_hi_o      (gate_hi_o[2*b+1]),
                .b_lo_o      (gate_lo_o[2*b+1])
            );
        end
    endgenerate

    // Status outputs; the undervoltage monitor itself is never gated by idle.
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            pump_en_o            <= 1'b0;
            bridge_word_o        <= WORD_RESET;
            timing_config_word_o <= WORD_RESET;
        end
        else
        begin
            pump_en_o            <= idle_rel && !clear_port;
            bridge_word_o        <= word0_q;
            timing_config_word_o <= word1_q;
        end
    end

endmodule : stepper_timing_ctrl

/* File: stepper_pkg.sv */
// Package with word layout, field positions, codes and timing constants for the stepper timing logic.
package stepper_pkg;

    // Serial word geometry.
    localparam int WORD_BITS        = 19;
    localparam int SEL_POS          = 0;
    localparam int IDLE_RELEASE_POS = 18;

    // Timing configuration word field positions.
    localparam int BLANK_LSB   = 1;
    localparam int OFF_LSB     = 3;
    localparam int FAST_LSB    = 8;
    localparam int CLKSEL_LSB  = 12;
    localparam int RECT_LSB    = 14;
    localparam int TEST_LSB    = 16;

    // Current code, phase and mode positions in the bridge word.
    localparam int DAC1_LSB    = 1;
    localparam int DAC2_LSB    = 7;
    localparam int PHASE1_POS  = 13;
    localparam int PHASE2_POS  = 14;
    localparam int MODE1_POS   = 15;
    localparam int MODE2_POS   = 16;

    // Reset value of both serial words.
    localparam logic [17:0] WORD_RESET = 18'h0_0000;

    // Blanking lengths in timebase periods.
    localparam logic [3:0] BLANK_4  = 4'h4;
    localparam logic [3:0] BLANK_6  = 4'h6;
    localparam logic [3:0] BLANK_8  = 4'h8;
    localparam logic [3:0] BLANK_12 = 4'hc;

    // Per-step periods of the off and fast-decay counters.
    localparam logic [8:0] STEP_PERIODS = 9'h008;

    // Timing clock source codes.
    typedef enum logic [1:0] {
        CLK_INTERNAL = 2'b00,
        CLK_EXT_DIV1 = 2'b01,
        CLK_EXT_DIV2 = 2'b10,
        CLK_EXT_DIV4 = 2'b11
    } clk_src_e;

    // Rectifier mode codes.
    typedef enum logic [1:0] {
        RECT_ACTIVE  = 2'b00,
        RECT_OFF     = 2'b01,
        RECT_PASSIVE = 2'b10,
        RECT_LOWSIDE = 2'b11
    } rect_mode_e;

    // Per-bridge chopping states.
    typedef enum logic [1:0] {
        ST_DRIVE = 2'b00,
        ST_FAST  = 2'b01,
        ST_SLOW  = 2'b10,
        ST_BLANK = 2'b11
    } chop_state_e;

endpackage : stepper_pkg

/* File: timing_cfg_if.sv */
// Interface carrying the decoded timing configuration to each bridge chopper.
interface timing_cfg_if;
    logic [1:0] blank_code;
    logic [4:0] off_code;
    logic [3:0] fast_code;
    logic [1:0] rect_mode;
    logic       tick;
    logic       run;

    modport src (output blank_code, off_code, fast_code, rect_mode, tick, run);
    modport dst (input  blank_code, off_code, fast_code, rect_mode, tick, run);
endinterface : timing_cfg_if

/* File: bridge_chopper.sv */
// Fixed off-time chopper for one full bridge, with blanking and decay selection.
module bridge_chopper
    import stepper_pkg::*;
(
    input  wire logic         clock_i,       // System clock.
    input  wire logic         sys_rst_i,     // Synchronous reset.
    timing_cfg_if.dst         cfg,           // Shared timing settings.
    input  wire logic [5:0]   dac_i,         // Current code, zero disables.
    input  wire logic         phase_i,       // Current direction.
    input  wire logic         slow_only_i,   // One selects slow decay only.
    input  wire logic         trip_i,        // Sense comparator output.
    input  wire logic         zero_i,        // Zero load current detected.
    input  wire logic         rev_lim_i,     // Reversed current at limit.
    output logic              a_hi_o,        // Output A high-side gate.
    output logic              a_lo_o,        // Output A low-side gate.
    output logic              b_hi_o,        // Output B high-side gate.
    output logic              b_lo_o         // Output B low-side gate.
);
    import stepper_pkg::*;

    chop_state_e state_q, state_d;
    logic [8:0]  cnt_q,   cnt_d;
    logic        phase_q;
    logic        sr_cut_q, sr_cut_d;

    // Off-time and fast-decay lengths in periods: (1+N)*8-1.
    wire  [8:0] off_len   = 9'((10'(cfg.off_code) + 10'd1) * 10'(STEP_PERIODS) - 10'd1);
    wire  [8:0] fast_len  = 9'((9'(cfg.fast_code) + 9'd1) * STEP_PERIODS - 9'd1);
    wire        enabled   = cfg.run && (dac_i != 6'h00);
    wire        phase_chg = phase_q != phase_i;
    wire  [3:0] blank_len = (cfg.blank_code == 2'b00) ? BLANK_4 :
                            (cfg.blank_code == 2'b01) ? BLANK_6 :
                            (cfg.blank_code == 2'b10) ? BLANK_8 : BLANK_12;
    // Fast decay holds while the count is below fast_len; a longer fast
    // setting simply keeps it for the whole off-time.
    wire        in_fast   = !slow_only_i && (cnt_q < fast_len);

    // Next-state logic of the chopper.
    always_comb
    begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        sr_cut_d = sr_cut_q;
        if (!enabled)
        begin
            state_d  = ST_FAST;
            cnt_d    = 9'h000;
            sr_cut_d = 1'b0;
        end
        else if (phase_chg)
        begin
            state_d = ST_BLANK;
            cnt_d   = 9'h000;
        end
        else if (cfg.tick)
        begin
            case (state_q)
                ST_DRIVE:
                begin
                    if (trip_i)
                    begin
                        state_d  = in_fast ? ST_FAST : ST_SLOW;
                        cnt_d    = 9'h000;
                        sr_cut_d = 1'b0;
                    end
                end
                ST_FAST, ST_SLOW:
                begin
                    if (cnt_q + 9'h001 >= off_len)
                    begin
                        state_d = ST_BLANK;
                        cnt_d   = 9'h000;
                    end
                    else
                    begin
                        cnt_d   = cnt_q + 9'h001;
                        state_d = (!slow_only_i && (cnt_d < fast_len)) ? ST_FAST : ST_SLOW;
                    end
                    // Rectifier cut-off on zero or reversed-limit current.
                    if ((cfg.rect_mode == RECT_ACTIVE && zero_i) ||
                        (cfg.rect_mode == RECT_PASSIVE && rev_lim_i))
                        sr_cut_d = 1'b1;
                end
                ST_BLANK:
                begin
                    // Comparator is ignored here so the turn-on spike cannot trip.
                    if (cnt_q + 9'h001 >= 9'(blank_len))
                    begin
                        state_d = ST_DRIVE;
                        cnt_d   = 9'h000;
                    end
                    else
                        cnt_d = cnt_q + 9'h001;
                end
                default:
                begin
                    state_d = ST_BLANK;
                    cnt_d   = 9'h000;
                end
            endcase
        end
    end

    // State registers; phase is tracked so a change restarts blanking.
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            state_q  <= ST_FAST;
            cnt_q    <= 9'h000;
            phase_q  <= 1'b0;
            sr_cut_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            phase_q  <= phase_i;
            sr_cut_q <= sr_cut_d;
        end
    end

    // Gate drive. Driving phase: A high/B low for phase 1.
    // Off-time: source side chopped; in low-side mode fast decay is not reversed
    // and both low sides recirculate.
    wire drive    = enabled && (state_q == ST_DRIVE || state_q == ST_BLANK);
    wire decay    = enabled && (state_q == ST_FAST || state_q == ST_SLOW);
    wire sr_ok    = (cfg.rect_mode != RECT_OFF) && !sr_cut_q;
    wire low_only = cfg.rect_mode == RECT_LOWSIDE;
    wire fast_now = state_q == ST_FAST;
    // With rectification on and not cut, fast decay reverses the bridge except in low-side mode; slow decay shorts the low sides.
    wire sink_a   = phase_i ? 1'b0 : 1'b1;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            a_hi_o <= 1'b0;
            a_lo_o <= 1'b0;
            b_hi_o <= 1'b0;
            b_lo_o <= 1'b0;
        end
        else
        begin
            a_hi_o <= drive && phase_i
                   || decay && sr_ok && !low_only && fast_now && !phase_i;
            b_hi_o <= drive && !phase_i
                   || decay && sr_ok && !low_only && fast_now && phase_i;
            a_lo_o <= drive && sink_a
                   || decay && sr_ok && (low_only || !fast_now || phase_i);
            b_lo_o <= drive && !sink_a
                   || decay && sr_ok && (low_only || !fast_now || !phase_i);
        end
    end

endmodule : bridge_chopper

/* File: stepper_timing_ctrl_properties.sv */
// Checker on the stepper timing control top ports.
module stepper_timing_ctrl_properties
(
    input wire logic        clock_i,                // Clock.
    input wire logic        sys_rst_i,              // Reset.
    input wire logic        ser_strobe_i,           // Strobe.
    input wire logic        sleep_n_i,              // Sleep.
    input wire logic        timing_source_pin_i,    // External timebase.
    input wire logic        int_osc_i,              // Internal oscillator.
    input wire logic        over_temp_i,            // Fault.
    input wire logic        pump_supply_low_i,      // Fault.
    input wire logic        sink_gate_supply_low_i, // Fault.
    input wire logic        undervoltage_lockout_i, // Low logic supply.
    input wire logic        pump_en_o,              // Pump enable.
    input wire logic        master_timebase_o,      // Timebase pulse.
    input wire logic [17:0] bridge_word_o,          // Bridge word.
    input wire logic [17:0] timing_config_word_o,   // Timing word.
    input wire logic [3:0]  gate_hi_o,              // High sides.
    input wire logic [3:0]  gate_lo_o               // Low sides.
);
    // Everything is judged on the system clock and rests while reset is high.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic fault_any;
    logic tb_live;
    // A fault of any kind, and a timebase that is allowed to run.
    assign fault_any = over_temp_i | pump_supply_low_i | sink_gate_supply_low_i;
    assign tb_live   = sleep_n_i & ~undervoltage_lockout_i & timing_config_word_o[17];

    a_sleep_clears: assert property (
        !sleep_n_i |-> ##2 (bridge_word_o == 18'h0_0000 && timing_config_word_o == 18'h0_0000))
        else $error("words kept during sleep");
    a_undervoltage_lockout_clears: assert property (
        undervoltage_lockout_i |-> ##2 (bridge_word_o | timing_config_word_o) == 18'h0_0000)
        else $error("words kept under low supply");
    a_sleep_off: assert property (
        !sleep_n_i [*2] |-> ##1 ({gate_hi_o, gate_lo_o} == 8'h00 && !pump_en_o))
        else $error("drive left on in sleep");
    a_fault_off: assert property (
        fault_any [*2] |-> ##1 {gate_hi_o, gate_lo_o} == 8'h00)
        else $error("gates on during fault");
    a_idle_off: assert property (
        !timing_config_word_o[17] [*3] |-> ({gate_hi_o, gate_lo_o} == 8'h00 && !pump_en_o))
        else $error("drive or pump on while idle");
    a_bridge_off: assert property (
        bridge_word_o[5:0] == 6'h00 [*3] |-> (gate_hi_o[1:0] | gate_lo_o[1:0]) == 2'b00)
        else $error("bridge one driven with zero code");
    a_word_hold: assert property (
        (ser_strobe_i && sleep_n_i && !undervoltage_lockout_i) [*4]
        |-> $stable(timing_config_word_o) && $stable(bridge_word_o))
        else $error("word changed without a write");
    a_tick_int: assert property (
        tb_live && $stable(timing_config_word_o)
        && timing_config_word_o[12:11] == 2'b00 && $rose(int_osc_i)
        |-> ##[1:3] master_timebase_o) else $error("no tick from internal source");
    a_tick_ext: assert property (
        tb_live && $stable(timing_config_word_o)
        && timing_config_word_o[12:11] == 2'b01 && $rose(timing_source_pin_i)
        |-> ##[1:3] master_timebase_o) else $error("no tick from external source");
    a_tick_pulse: assert property (
        master_timebase_o |=> !master_timebase_o) else $error("tick wider than one cycle");
endmodule : stepper_timing_ctrl_properties

bind stepper_timing_ctrl stepper_timing_ctrl_properties u_props (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .ser_strobe_i(ser_strobe_i), .sleep_n_i(sleep_n_i),
    .timing_source_pin_i(timing_source_pin_i), .int_osc_i(int_osc_i),
    .over_temp_i(over_temp_i), .pump_supply_low_i(pump_supply_low_i),
    .sink_gate_supply_low_i(sink_gate_supply_low_i),
    .undervoltage_lockout_i(undervoltage_lockout_i), .pump_en_o(pump_en_o),
    .master_timebase_o(master_timebase_o), .bridge_word_o(bridge_word_o),
    .timing_config_word_o(timing_config_word_o), .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o));

/* File: serial_host_model.sv */
// Host model that writes words through the three-wire serial port.
module serial_host_model
(
    input  wire logic        clock_i,      // System clock.
    input  wire logic        go_i,         // Start one write.
    input  wire logic [19:0] word_i,       // Word, bit 0 goes last.
    input  wire logic [4:0]  nbits_i,      // Bits to send.
    input  wire logic [2:0]  hold_i,       // Cycles per level, two or more.
    output logic             ser_clk_o,    // Serial clock, low between frames.
    output logic             ser_data_o,   // Serial data.
    output logic             ser_strobe_o, // Strobe, idles high.
    output logic             busy_o        // Write in progress.
);
    timeunit 1ns;
    timeprecision 1ps;
    int i;
    initial
    begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        ser_strobe_o = 1'b1;
        busy_o = 1'b0;
    end
    // Strobe drops only for a write; data settles while the clock is low so the
    // rising edge finds it stable. The data line is inverted after the frame, since
    // nothing holds it then.
    always @(posedge clock_i)
    begin
        if (go_i && !busy_o)
        begin
            busy_o <= 1'b1;
            ser_strobe_o <= 1'b0;
            for (i = int'(nbits_i); i > 0; i--)
            begin
                ser_data_o <= word_i[i-1];
                ser_clk_o <= 1'b0;
                repeat (hold_i) @(posedge clock_i);
                ser_clk_o <= 1'b1;
                repeat (hold_i) @(posedge clock_i);
            end
            ser_clk_o <= 1'b0;
            ser_data_o <= ~ser_data_o;
            ser_strobe_o <= 1'b1;
            repeat (2) @(posedge clock_i);
            busy_o <= 1'b0;
        end
    end
endmodule : serial_host_model

/* File: stepper_timing_ctrl_tb.sv */
// Self-checking testbench for the stepper timing control top.
module stepper_timing_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0, sys_rst_i = 1'b1, sleep_n_i = 1'b1, int_osc_i = 1'b0, go = 1'b0;
    logic timing_source_pin_i = 1'b0, over_temp_i = 1'b0, pump_supply_low_i = 1'b0;
    logic sink_gate_supply_low_i = 1'b0, undervoltage_lockout_i = 1'b0;
    logic [1:0] trip_i = 2'b00;
    logic [19:0] word = 20'h0_0000;
    logic [18:0] word_v;
    logic [4:0] nbits = 5'h13;
    logic [2:0] hold = 3'h2;
    logic ser_clk, ser_data, ser_strobe, busy, pump_en_o, master_timebase_o;
    logic [17:0] bridge_word_o, timing_config_word_o;
    logic [3:0] gate_hi_o, gate_lo_o;
    logic [35:0] model_w = 36'h0, prev_w = 36'h0;
    logic [35:0] exp_q[$];
    int err_total = 0, check_count = 0, osc_cnt = 0, ext_cnt = 0, pulses;
    int tb_exp[4] = '{60, 40, 20, 10};

    // 250 MHz clock.
    always #2 clock_i = ~clock_i;
    // Internal source rises every 4 cycles, external every 6.
    always @(posedge clock_i)
    begin
        osc_cnt <= osc_cnt + 1;
        int_osc_i <= osc_cnt[1];
        ext_cnt <= (ext_cnt == 5) ? 0 : ext_cnt + 1;
        timing_source_pin_i <= (ext_cnt < 3);
    end

    stepper_timing_ctrl u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ser_clk_i(ser_clk),
        .ser_data_i(ser_data), .ser_strobe_i(ser_strobe), .sleep_n_i(sleep_n_i),
        .timing_source_pin_i(timing_source_pin_i), .int_osc_i(int_osc_i),
        .over_temp_i(over_temp_i), .pump_supply_low_i(pump_supply_low_i),
        .sink_gate_supply_low_i(sink_gate_supply_low_i),
        .undervoltage_lockout_i(undervoltage_lockout_i), .trip_i(trip_i), .zero_i(2'b00),
        .rev_lim_i(2'b00), .pump_en_o(pump_en_o), .master_timebase_o(master_timebase_o),
        .bridge_word_o(bridge_word_o), .timing_config_word_o(timing_config_word_o),
        .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o));
    serial_host_model u_host (.clock_i(clock_i), .go_i(go), .word_i(word), .nbits_i(nbits),
        .hold_i(hold), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_strobe_o(ser_strobe),
        .busy_o(busy));

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // A word change is noted before it is caused, so the watcher never races it.
    task automatic note(input logic [35:0] w);
        if (w !== model_w)
            exp_q.push_back(w);
        model_w = w;
    endtask : note

    function automatic logic [35:0] nextw(input logic [18:0] w);
        return w[0] ? {model_w[35:18], w[18:1]} : {w[18:1], model_w[17:0]};
    endfunction : nextw

    // Timing word with zero counts and clear test bits.
    function automatic logic [18:0] tword(input logic idle, input logic [1:0] rect,
                                          input logic [1:0] clk);
        return {idle, 2'b00, rect, clk, 4'h0, 5'h00, 2'b00, 1'b1};
    endfunction : tword

    task automatic send(input logic [19:0] w, input logic [4:0] n);
        int k;
        word <= w;
        nbits <= n;
        hold <= 3'($urandom_range(2, 4));
        go <= 1'b1;
        repeat (2) @(posedge clock_i);
        go <= 1'b0;
        for (k = 0; busy === 1'b1; k++)
        begin
            if (k > 400)
            begin
                err_total++;
                $display("MISMATCH t=%0t serial write hung", $time);
                stop_test();
            end
            @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask : send

    task automatic wr(input logic [18:0] w);
        note(nextw(w));
        send({1'b0, w}, 5'd19);
    endtask : wr

    // Each visible word change takes the oldest note.
    always @(posedge clock_i)
    begin
        prev_w <= {bridge_word_o, timing_config_word_o};
        if (!sys_rst_i && {bridge_word_o, timing_config_word_o} !== prev_w)
        begin
            if (exp_q.size() == 0)
                check(36'h1, 36'h0);
            else
                check({bridge_word_o, timing_config_word_o}, exp_q.pop_front());
        end
    end

    initial
    begin
        void'($urandom(32'h342b));
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        for (int n = 0; n < 8; n++)
            wr(19'($urandom) & 19'h4_ffff);
        // A short write is dropped; a long one keeps its last 19 bits.
        send(20'h0_5555, 5'd18);
        word_v = 19'($urandom) & 19'h4_ffff;
        note(nextw(word_v));
        send({1'b1, word_v}, 5'd20);
        check(36'(exp_q.size()), 36'h0);
        $display("test serial words done");
        for (int c = 0; c < 4; c++)
        begin
            wr(tword(1'b1, 2'b01, 2'(c)));
            pulses = 0;
            repeat (240)
            begin
                @(posedge clock_i);
                if (master_timebase_o === 1'b1)
                    pulses++;
            end
            check(36'(pulses >= tb_exp[c] - 1 && pulses <= tb_exp[c] + 1), 36'h1);
        end
        $display("test timebase done");
        for (int p = 0; p < 4; p++)
        begin
            wr({4'h0, p[1], p[0], 6'h3f, 6'h01, 1'b0});
            repeat (200) @(posedge clock_i);
            check({32'h0, gate_hi_o}, {32'h0, ~p[1], p[1], ~p[0], p[0]});
            check({32'h0, gate_lo_o}, {32'h0, p[1], ~p[1], p[0], ~p[0]});
        end
        // A trip with rectification disabled leaves bridge one dark for the off-time.
        trip_i <= 2'b01;
        repeat (26) @(posedge clock_i);
        trip_i <= 2'b00;
        repeat (4) @(posedge clock_i);
        check({32'h0, gate_hi_o | gate_lo_o}, 36'hc);
        repeat (200) @(posedge clock_i);
        check({32'h0, gate_hi_o}, 36'h5);
        $display("test chopper done");
        for (int f = 0; f < 3; f++)
        begin
            {sink_gate_supply_low_i, pump_supply_low_i, over_temp_i} <= 3'(1 << f);
            repeat (4) @(posedge clock_i);
            check({32'h0, gate_hi_o | gate_lo_o}, 36'h0);
            {sink_gate_supply_low_i, pump_supply_low_i, over_temp_i} <= 3'b000;
            repeat (200) @(posedge clock_i);
            check({32'h0, gate_hi_o}, 36'h5);
        end
        check({35'h0, pump_en_o}, 36'h1);
        wr({4'h0, 2'b11, 6'h3f, 6'h00, 1'b0});
        check({32'h0, gate_hi_o | gate_lo_o}, 36'hc);
        wr(tword(1'b0, 2'b01, 2'b00));
        check({31'h0, pump_en_o, gate_hi_o | gate_lo_o}, 36'h0);
        $display("test disables done");
        note(36'h0);
        sleep_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check({31'h0, pump_en_o, gate_hi_o | gate_lo_o}, 36'h0);
        sleep_n_i <= 1'b1;
        wr(tword(1'b1, 2'b10, 2'b11));
        note(36'h0);
        undervoltage_lockout_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        check({31'h0, pump_en_o, gate_hi_o | gate_lo_o}, 36'h0);
        undervoltage_lockout_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        check(36'(exp_q.size()), 36'h0);
        $display("test sleep and lockout done");
        stop_test();
    end
endmodule : stepper_timing_ctrl_tb
